// *** design/fspe_flash_array.sv ***
// 64K byte flash array with page erase, byte program and read
`timescale 1ns/10ps
`default_nettype none
module fspe_flash_array (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // engine side
    fspe_flash_if.array      fl
);
    logic [7:0]               mem [0:65535];
    logic                     active;
    logic                     next_active;
    logic [8:0]               cnt;
    logic [8:0]               next_cnt;
    logic                     next_done;
    logic [7:0]               next_rdata;
    logic                     wr_en;
    logic [15:0]              wr_addr;
    logic [7:0]               wr_val;

    always_comb
    begin
        next_active = active;
        next_cnt    = cnt;
        next_done   = 1'b0;
        next_rdata  = fl.rdata;
        wr_en       = 1'b0;
        wr_addr     = fl.addr;
        wr_val      = fspe_pkg::ERASED_BYTE;
        if (fl.start)
        begin
            next_active = 1'b1;
            next_cnt    = '0;
        end
        else if (active && fl.step)
        begin
            case (fl.op)
                fspe_pkg::FSPE_OP_READ:
                begin
                    next_rdata  = mem[fl.addr];
                    next_done   = 1'b1;
                    next_active = 1'b0;
                end
                fspe_pkg::FSPE_OP_PROGRAM:
                begin
                    wr_en       = 1'b1;
                    wr_val      = mem[fl.addr] & fl.wdata;
                    next_done   = 1'b1;
                    next_active = 1'b0;
                end
                fspe_pkg::FSPE_OP_ERASE:
                begin
                    // one byte per step keeps the write port single
                    wr_en   = 1'b1;
                    wr_addr = {fl.addr[15:fspe_pkg::PAGE_BITS], cnt};
                    next_cnt = cnt + 9'h001;
                    if (cnt == fspe_pkg::PAGE_LAST)
                    begin
                        next_done   = 1'b1;
                        next_active = 1'b0;
                    end
                end
                default:
                begin
                    next_done   = 1'b1;
                    next_active = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active   <= 1'b0;
            cnt      <= '0;
            fl.done  <= 1'b0;
            fl.rdata <= '0;
        end
        else
        begin
            active   <= next_active;
            cnt      <= next_cnt;
            fl.done  <= next_done;
            fl.rdata <= next_rdata;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_val;
    end

    chk_erase_ones: assert property (@(posedge pclk) disable iff (!presetn)
        active && fl.step && fl.op == fspe_pkg::FSPE_OP_ERASE
        |=> mem[$past(wr_addr)] == fspe_pkg::ERASED_BYTE)
        else $error("erased byte not all ones");
    chk_program_and: assert property (@(posedge pclk) disable iff (!presetn)
        active && fl.step && fl.op == fspe_pkg::FSPE_OP_PROGRAM
        |=> (mem[$past(fl.addr)] & ~$past(mem[fl.addr])) == 8'h00)
        else $error("program raised a bit to one");
endmodule : fspe_flash_array
`default_nettype wire

// *** design/fspe_flash_if.sv ***
// link between the engine control and the flash array
`timescale 1ns/10ps
`default_nettype none
interface fspe_flash_if;
    logic                  start;
    fspe_pkg::fspe_op_e    op;
    logic [15:0]           addr;
    logic [7:0]            wdata;
    logic                  step;
    logic                  done;
    logic [7:0]            rdata;
    modport ctrl  (output start, op, addr, wdata, step, input done, rdata);
    modport array (input start, op, addr, wdata, step, output done, rdata);
endinterface : fspe_flash_if
`default_nettype wire

// *** design/fspe_pkg.sv ***
// constants and types of the flash self-program engine
//////////////////////////////////////////////////////////////////////
// What this block does
// - three operations: erase, program, read
// - select codes 03 erase, 02 program, 01 read
// - start only after 46h then b9h trigger
// - page is 512 bytes, aligned low bits
// - erase sets every page bit to one
// - program only clears bits to zero
// - program writes data byte at address
// - read loads data byte from address
// - cpu stalled until operation completes
// - control bit 7 enables the engine
// - boot code modifies app and data; app only data
// - data region low bound from register
// - boot region size set by option, 4K max
// - target beyond data region is ignored
//////////////////////////////////////////////////////////////////////
package fspe_pkg;
    localparam logic [7:0] OFF_OP_SELECT  = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH  = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW   = 8'h08;
    localparam logic [7:0] OFF_DATA_BYTE  = 8'h0c;
    localparam logic [7:0] OFF_TRIGGER    = 8'h10;
    localparam logic [7:0] OFF_CONTROL    = 8'h14;
    localparam logic [7:0] OFF_CLOCK_CFG  = 8'h18;
    localparam logic [7:0] OFF_LOW_BOUND  = 8'h1c;
    localparam logic [7:0] OFF_STATUS     = 8'h20;
    localparam logic [7:0] SEL_STANDBY    = 8'h00;
    localparam logic [7:0] SEL_READ       = 8'h01;
    localparam logic [7:0] SEL_PROGRAM    = 8'h02;
    localparam logic [7:0] SEL_ERASE      = 8'h03;
    localparam logic [7:0] UNLOCK_FIRST   = 8'h46;
    localparam logic [7:0] UNLOCK_SECOND  = 8'hb9;
    localparam logic [7:0] ERASED_BYTE    = 8'hff;
    localparam logic [7:0] LOW_BOUND_RST  = 8'h00;
    localparam int         CTRL_EN_BIT    = 7;
    localparam int         DIV_W          = 6;
    localparam int         PAGE_BITS      = 9;
    localparam int         ADDR_W         = 16;
    localparam int         BOOT_SEL_W     = 4;
    localparam logic [3:0] BOOT_SEL_MAX   = 4'h8;
    localparam logic [16:0] FLASH_SIZE    = 17'h10000;
    localparam logic [8:0] PAGE_LAST      = 9'h1ff;
    localparam int         ST_BUSY        = 0;
    localparam int         ST_IGNORED     = 1;
    localparam int         ST_ARMED       = 2;

    typedef enum logic [1:0] {
        FSPE_OP_NONE    = 2'h0,
        FSPE_OP_READ    = 2'h1,
        FSPE_OP_PROGRAM = 2'h2,
        FSPE_OP_ERASE   = 2'h3
    } fspe_op_e;

    // any undocumented select value counts as standby
    function automatic fspe_op_e fspe_decode_op(input logic [7:0] sel);
        case (sel)
            SEL_READ:    fspe_decode_op = FSPE_OP_READ;
            SEL_PROGRAM: fspe_decode_op = FSPE_OP_PROGRAM;
            SEL_ERASE:   fspe_decode_op = FSPE_OP_ERASE;
            default:     fspe_decode_op = FSPE_OP_NONE;
        endcase
    endfunction : fspe_decode_op
endpackage : fspe_pkg

// *** design/fspe_top.sv ***
// flash self-program engine: apb registers, unlock, region guard, stall
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fspe_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // cpu side
    input  wire logic        cpu_in_boot,
    input  wire logic [3:0]  boot_size_opt,
    output var  logic        cpu_stall
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_ARMED = 3'b010,
        S_BUSY  = 3'b100
    } fspe_state_e;

    fspe_flash_if fl ();

    fspe_state_e              state;
    fspe_state_e              next_state;
    logic [7:0]               op_select;
    logic [7:0]               next_op_select;
    logic [7:0]               addr_high;
    logic [7:0]               next_addr_high;
    logic [7:0]               addr_low;
    logic [7:0]               next_addr_low;
    logic [7:0]               data_byte;
    logic [7:0]               next_data_byte;
    logic [7:0]               control;
    logic [7:0]               next_control;
    logic [7:0]               clock_cfg;
    logic [7:0]               next_clock_cfg;
    logic [7:0]               low_bound;
    logic [7:0]               next_low_bound;
    logic                     ignored;
    logic                     next_ignored;
    logic [5:0]               div_cnt;
    logic [5:0]               next_div_cnt;
    logic [3:0]               boot_sel;
    logic [3:0]               next_boot_sel;
    logic                     strap_taken;
    logic [31:0]              next_prdata;
    logic                     next_pready;
    logic                     next_pslverr;
    logic                     next_cpu_stall;
    logic                     next_start;
    logic                     next_step;
    logic                     wr_acc;
    logic                     wr_trig;
    logic [15:0]              target;
    logic [16:0]              boot_start;
    logic                     in_range;
    logic                     allowed;
    logic                     trig_valid;
    fspe_pkg::fspe_op_e       op_now;

    ////////////////////////////////////////////////////////////////////
    // address decode and region guard

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            fspe_pkg::OFF_OP_SELECT, fspe_pkg::OFF_ADDR_HIGH,
            fspe_pkg::OFF_ADDR_LOW,  fspe_pkg::OFF_DATA_BYTE,
            fspe_pkg::OFF_TRIGGER,   fspe_pkg::OFF_CONTROL,
            fspe_pkg::OFF_CLOCK_CFG, fspe_pkg::OFF_LOW_BOUND,
            fspe_pkg::OFF_STATUS:    is_mapped = 1'b1;
            default:                 is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    assign wr_acc  = psel && penable && pready && pwrite && is_mapped(paddr);
    assign wr_trig = wr_acc && paddr == fspe_pkg::OFF_TRIGGER;
    assign target  = {addr_high, addr_low};
    assign op_now  = fspe_pkg::fspe_decode_op(op_select);
    // data region ends just below the boot region
    assign boot_start = fspe_pkg::FLASH_SIZE - {4'h0, boot_sel, 9'h000};
    assign in_range   = {1'b0, target} < boot_start;
    always_comb
    begin
        allowed = in_range;
        // app code may touch only the data region; reads are not modifies
        if (!cpu_in_boot && op_now != fspe_pkg::FSPE_OP_READ)
            allowed = in_range && target >= {low_bound, 8'h00};
    end
    assign trig_valid = control[fspe_pkg::CTRL_EN_BIT]
                        && op_now != fspe_pkg::FSPE_OP_NONE && allowed;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_state     = state;
        next_op_select = op_select;
        next_addr_high = addr_high;
        next_addr_low  = addr_low;
        next_data_byte = data_byte;
        next_control   = control;
        next_clock_cfg = clock_cfg;
        next_low_bound = low_bound;
        next_ignored   = ignored;
        next_div_cnt   = div_cnt;
        next_boot_sel  = boot_sel;
        next_start     = 1'b0;
        next_step      = 1'b0;
        next_cpu_stall = cpu_stall;
        if (!strap_taken)
            next_boot_sel = (boot_size_opt > fspe_pkg::BOOT_SEL_MAX)
                            ? fspe_pkg::BOOT_SEL_MAX : boot_size_opt;
        // operands are frozen while the array works on them
        if (wr_acc && state != S_BUSY)
        begin
            case (paddr)
                fspe_pkg::OFF_OP_SELECT: next_op_select = pwdata[7:0];
                fspe_pkg::OFF_ADDR_HIGH: next_addr_high = pwdata[7:0];
                fspe_pkg::OFF_ADDR_LOW:  next_addr_low  = pwdata[7:0];
                fspe_pkg::OFF_DATA_BYTE: next_data_byte = pwdata[7:0];
                fspe_pkg::OFF_CONTROL:   next_control   = pwdata[7:0];
                fspe_pkg::OFF_CLOCK_CFG: next_clock_cfg = pwdata[7:0];
                fspe_pkg::OFF_LOW_BOUND: next_low_bound = pwdata[7:0];
                fspe_pkg::OFF_STATUS:
                    if (pwdata[fspe_pkg::ST_IGNORED])
                        next_ignored = 1'b0;
                default: next_ignored = ignored;
            endcase
        end
        case (state)
            S_IDLE:
                if (wr_trig && pwdata[7:0] == fspe_pkg::UNLOCK_FIRST)
                    next_state = S_ARMED;
            S_ARMED:
                if (wr_trig)
                begin
                    if (pwdata[7:0] == fspe_pkg::UNLOCK_SECOND)
                    begin
                        if (trig_valid)
                        begin
                            next_state     = S_BUSY;
                            next_start     = 1'b1;
                            next_cpu_stall = 1'b1;
                            next_div_cnt   = clock_cfg[fspe_pkg::DIV_W-1:0];
                        end
                        else
                        begin
                            next_state   = S_IDLE;
                            next_ignored = 1'b1;
                        end
                    end
                    else if (pwdata[7:0] != fspe_pkg::UNLOCK_FIRST)
                        next_state = S_IDLE;
                end
            S_BUSY:
            begin
                if (div_cnt == '0)
                begin
                    next_step    = 1'b1;
                    next_div_cnt = clock_cfg[fspe_pkg::DIV_W-1:0];
                end
                else
                    next_div_cnt = div_cnt - 6'h01;
                if (fl.done)
                begin
                    next_step      = 1'b0;
                    next_state     = S_IDLE;
                    next_cpu_stall = 1'b0;
                    if (op_now == fspe_pkg::FSPE_OP_READ)
                        next_data_byte = fl.rdata;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // apb answer: read data and error prepared in the setup cycle

    always_comb
    begin
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !is_mapped(paddr);
        next_prdata  = '0;
        if (psel && !penable)
        begin
            case (paddr)
                fspe_pkg::OFF_OP_SELECT: next_prdata[7:0] = op_select;
                fspe_pkg::OFF_ADDR_HIGH: next_prdata[7:0] = addr_high;
                fspe_pkg::OFF_ADDR_LOW:  next_prdata[7:0] = addr_low;
                fspe_pkg::OFF_DATA_BYTE: next_prdata[7:0] = data_byte;
                fspe_pkg::OFF_CONTROL:   next_prdata[7:0] = control;
                fspe_pkg::OFF_CLOCK_CFG: next_prdata[7:0] = clock_cfg;
                fspe_pkg::OFF_LOW_BOUND: next_prdata[7:0] = low_bound;
                fspe_pkg::OFF_STATUS:
                begin
                    next_prdata[fspe_pkg::ST_BUSY]    = state == S_BUSY;
                    next_prdata[fspe_pkg::ST_IGNORED] = ignored;
                    next_prdata[fspe_pkg::ST_ARMED]   = state == S_ARMED;
                end
                default: next_prdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state       <= S_IDLE;
            op_select   <= fspe_pkg::SEL_STANDBY;
            addr_high   <= '0;
            addr_low    <= '0;
            data_byte   <= '0;
            control     <= '0;
            clock_cfg   <= '0;
            low_bound   <= fspe_pkg::LOW_BOUND_RST;
            ignored     <= 1'b0;
            div_cnt     <= '0;
            boot_sel    <= '0;
            strap_taken <= 1'b0;
            prdata      <= '0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            cpu_stall   <= 1'b0;
            fl.start    <= 1'b0;
            fl.step     <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            op_select   <= next_op_select;
            addr_high   <= next_addr_high;
            addr_low    <= next_addr_low;
            data_byte   <= next_data_byte;
            control     <= next_control;
            clock_cfg   <= next_clock_cfg;
            low_bound   <= next_low_bound;
            ignored     <= next_ignored;
            div_cnt     <= next_div_cnt;
            boot_sel    <= next_boot_sel;
            strap_taken <= 1'b1;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            cpu_stall   <= next_cpu_stall;
            fl.start    <= next_start;
            fl.step     <= next_step;
        end
    end

    assign fl.op    = op_now;
    assign fl.addr  = target;
    assign fl.wdata = data_byte;

    fspe_flash_array u_array (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (fl.array)
    );

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence unlock_seq;
        state == S_ARMED && wr_trig && pwdata[7:0] == fspe_pkg::UNLOCK_SECOND;
    endsequence

    chk_trigger_start: assert property (unlock_seq and trig_valid
        |=> state == S_BUSY && cpu_stall && fl.start && div_cnt == clock_cfg[fspe_pkg::DIV_W-1:0])
        else $error("valid unlock did not start operation");
    chk_break_cancel: assert property (state == S_ARMED && wr_trig
        && pwdata[7:0] != fspe_pkg::UNLOCK_SECOND
        && pwdata[7:0] != fspe_pkg::UNLOCK_FIRST |=> state == S_IDLE)
        else $error("broken unlock left engine armed");
    chk_range_ignore: assert property (unlock_seq and !in_range
        |=> state == S_IDLE && ignored && !cpu_stall)
        else $error("out of range trigger not ignored");
    chk_app_region: assert property (unlock_seq and !cpu_in_boot
        && op_now == fspe_pkg::FSPE_OP_PROGRAM && target < {low_bound, 8'h00}
        |=> state != S_BUSY)
        else $error("app code modified outside data region");
    chk_enable_needed: assert property (unlock_seq
        and !control[fspe_pkg::CTRL_EN_BIT] |=> !cpu_stall)
        else $error("operation started while disabled");
    chk_bad_select: assert property (unlock_seq
        and op_select > fspe_pkg::SEL_ERASE |=> state == S_IDLE)
        else $error("undocumented select started an operation");
    chk_stall_span: assert property ($rose(cpu_stall)
        |-> $past(state) == S_ARMED && state == S_BUSY)
        else $error("stall without a trigger");
    chk_stall_end: assert property (state == S_BUSY && fl.done
        |=> !cpu_stall && state == S_IDLE)
        else $error("stall outlived the operation");
    chk_read_load: assert property (state == S_BUSY && fl.done
        && op_now == fspe_pkg::FSPE_OP_READ |=> data_byte == $past(fl.rdata))
        else $error("read data not loaded");
endmodule : fspe_top
`default_nettype wire

// *** tb/flash_self_program_engine_tb.sv ***
// self-checking bench of the flash self-program engine
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_engine_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        cpu_in_boot = 1'b1;
    logic [3:0]  boot_size_opt = 4'h2;
    logic        psel, penable, pwrite, pready, pslverr, cpu_stall;
    logic [7:0]  paddr, dv, d1, d2;
    logic [31:0] pwdata, prdata, rnd;
    logic [32:0] expq[$];
    logic [32:0] exp_v;
    int          n_fail = 0;
    int          n_compared = 0;
    int          st;

    always #4 pclk = ~pclk;

    fspe_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_in_boot(cpu_in_boot), .boot_size_opt(boot_size_opt), .cpu_stall(cpu_stall));
    fspe_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .cpu_stall(cpu_stall));
    //////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        cpu.xfer(1'b0, a, 32'h0);
    endtask : rd
    // flash byte fetched by a read operation, then taken from the data byte
    task automatic rdb(input logic [15:0] a, input logic [7:0] e);
        cpu.run_op(fspe_pkg::SEL_READ, a, 8'h00, 1'b1, st);
        rd(fspe_pkg::OFF_DATA_BYTE, {25'h0, e});
    endtask : rdb
    // a refused trigger must not stall and must flag itself ignored
    task automatic refuse(input logic [7:0] s, input logic [15:0] a, input logic en);
        cpu.run_op(s, a, 8'h00, en, st);
        cmp(33'(st), 33'h0);
        rd(fspe_pkg::OFF_STATUS, 33'h2);
        wr(fspe_pkg::OFF_STATUS, 8'h02);
    endtask : refuse
    //////////////////////////////////////////////////////////////////////
    // read results are checked in the access cycle where pready stands
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            exp_v = expq.pop_front();
            cmp({pslverr, prdata}, exp_v);
        end
    end
    initial
    begin
        #(60000 * 8);
        n_fail++;
        report_and_stop();
    end
    initial
    begin
        rnd = $urandom(51);
        dv = 8'($urandom_range(3));
        d1 = 8'($urandom) | 8'h81;
        d2 = 8'($urandom) | 8'h01;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(fspe_pkg::OFF_CONTROL, 33'h0);
        rd(fspe_pkg::OFF_LOW_BOUND, 33'h0);
        rd(8'h40, 33'h100000000);
        wr(fspe_pkg::OFF_CLOCK_CFG, dv);
        cpu.run_op(fspe_pkg::SEL_ERASE, 16'h1200, 8'h00, 1'b1, st);
        cmp(33'(st >= 512), 33'h1);
        rdb(16'h1200 + 16'($urandom_range(511)), fspe_pkg::ERASED_BYTE);
        cpu.run_op(fspe_pkg::SEL_PROGRAM, 16'h1234, d1, 1'b1, st);
        cmp(33'(st > 0), 33'h1);
        rdb(16'h1234, d1);
        cpu.run_op(fspe_pkg::SEL_PROGRAM, 16'h1234, d2, 1'b1, st);
        rdb(16'h1234, d1 & d2);
        // armed then broken: the later second byte must not fire
        wr(fspe_pkg::OFF_CONTROL, 8'h80);
        wr(fspe_pkg::OFF_OP_SELECT, fspe_pkg::SEL_PROGRAM);
        wr(fspe_pkg::OFF_DATA_BYTE, 8'h00);
        wr(fspe_pkg::OFF_TRIGGER, fspe_pkg::UNLOCK_FIRST);
        wr(fspe_pkg::OFF_TRIGGER, 8'h12);
        wr(fspe_pkg::OFF_TRIGGER, fspe_pkg::UNLOCK_SECOND);
        rd(fspe_pkg::OFF_STATUS, 33'h0);
        wr(fspe_pkg::OFF_CONTROL, 8'h00);
        refuse(fspe_pkg::SEL_PROGRAM, 16'hfc10, 1'b1);
        refuse(fspe_pkg::SEL_PROGRAM, 16'h1234, 1'b0);
        refuse(fspe_pkg::SEL_STANDBY, 16'h1234, 1'b1);
        // undocumented select codes must behave as standby
        refuse(rnd[7:0] | 8'h04, 16'h1234, 1'b1);
        wr(fspe_pkg::OFF_LOW_BOUND, 8'h20);
        cpu_in_boot <= 1'b0;
        refuse(fspe_pkg::SEL_PROGRAM, 16'h1234, 1'b1);
        refuse(fspe_pkg::SEL_ERASE, 16'h1e00, 1'b1);
        cpu.run_op(fspe_pkg::SEL_ERASE, 16'hfa00, 8'h00, 1'b1, st);
        rdb(16'hfbff, fspe_pkg::ERASED_BYTE);
        rdb(16'h1234, d1 & d2);
        rd(fspe_pkg::OFF_STATUS, 33'h0);
        // reset again with an oversized strap: boot region clamps to 4K
        presetn       <= 1'b0;
        boot_size_opt <= 4'hf;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(fspe_pkg::OFF_CONTROL, 33'h0);
        refuse(fspe_pkg::SEL_READ, 16'hf000, 1'b1);
        report_and_stop();
    end
endmodule : flash_self_program_engine_tb
`default_nettype wire

// *** tb/fspe_cpu_model.sv ***
// cpu model: apb master that loads the engine registers and waits out stalls
`timescale 1ns/10ps
`default_nettype none
module fspe_cpu_model (
    // clock
    input  wire logic        pclk,
    // apb master
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic        pready,
    // stall from the engine
    input  wire logic        cpu_stall
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    //////////////////////////////////////////////////////////////////////
    // request held until the edge that samples pready high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    //////////////////////////////////////////////////////////////////////
    // loads select, address, data, unlocks, then parks the engine again
    task automatic run_op(input logic [7:0] s, input logic [15:0] a, input logic [7:0] d,
                          input logic en, output int stalled);
        stalled = 0;
        xfer(1'b1, fspe_pkg::OFF_CONTROL, {24'h0, en, 7'h0});
        xfer(1'b1, fspe_pkg::OFF_OP_SELECT, {24'h0, s});
        xfer(1'b1, fspe_pkg::OFF_ADDR_HIGH, {24'h0, a[15:8]});
        xfer(1'b1, fspe_pkg::OFF_ADDR_LOW, {24'h0, a[7:0]});
        xfer(1'b1, fspe_pkg::OFF_DATA_BYTE, {24'h0, d});
        xfer(1'b1, fspe_pkg::OFF_TRIGGER, {24'h0, fspe_pkg::UNLOCK_FIRST});
        xfer(1'b1, fspe_pkg::OFF_TRIGGER, {24'h0, fspe_pkg::UNLOCK_SECOND});
        // stall is registered on the firing edge itself, so it already shows at the first negedge
        repeat (2) @(negedge pclk);
        while (cpu_stall === 1'b1)
        begin
            stalled++;
            @(negedge pclk);
        end
        xfer(1'b1, fspe_pkg::OFF_OP_SELECT, {24'h0, fspe_pkg::SEL_STANDBY});
        xfer(1'b1, fspe_pkg::OFF_CONTROL, 32'h0);
    endtask : run_op
endmodule : fspe_cpu_model
`default_nettype wire
